/* verilog/sinc_rx_pkg.sv */
// Shared constants and types for the bitstream decimation filter
package sinc_rx_pkg;

  // Default oversampling ratio as a power of two (ratio 256)
  localparam int OSR_LOG2_DEF = 8;
  // Output word width
  localparam int OUT_W = 16;

  // Filter selection, one-hot
  typedef enum logic [2:0] {
    MODE_SINC3 = 3'b001,
    MODE_SINC2 = 3'b010,
    MODE_FAST  = 3'b100
  } mode_t;

  // Word periods to discard after reset or mode change
  localparam logic [2:0] SETTLE_SINC3 = 3'h3;
  localparam logic [2:0] SETTLE_SINC2 = 3'h2;
  localparam logic [2:0] SETTLE_FAST = 3'h4;

  // Saturated output code
  localparam logic [OUT_W-1:0] WORD_MAX = 16'hFFFF;
  localparam logic [OUT_W-1:0] WORD_RST = 16'h0000;

  typedef struct packed {
    logic [OUT_W-1:0] value;
    mode_t mode;
  } sample_t;

  localparam sample_t SAMPLE_RST = '{value: WORD_RST, mode: MODE_SINC3};

endpackage

/* verilog/sinc_rx.sv */
// Host-side decimating sinc filter for an isolated 1-bit modulator stream
`timescale 1ns/1ps
`default_nettype none

module sinc_rx
  import sinc_rx_pkg::*;
#(
  parameter int OSR_LOG2 = OSR_LOG2_DEF
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic mod_clk,
  input wire logic modulator_bitstream_out,
  input wire mode_t mode_sel,
  output sample_t word,
  output logic word_valid
);

  localparam int ACC_W = 3 * OSR_LOG2 + 1;
  localparam int SH3 = 3 * OSR_LOG2 - OUT_W;
  localparam int SH2 = 2 * OSR_LOG2 - OUT_W;
  localparam int SHF = 2 * OSR_LOG2 + 1 - OUT_W;
  localparam logic [OSR_LOG2-1:0] CNT_LAST = '1;
  // Three integrators and three combs; sinc2 and fast use only the first two of each
  localparam int INT_N = 3;
  localparam int COMB_N = 3;

  // Reset asserts at once but releases on each domain's own edge,
  // so no register sees release inside its recovery window
  logic mod_rst_s1_n_q;
  logic mod_nrst_q;
  logic sys_rst_s1_n_q;
  logic sys_nrst_q;

  always_ff @(posedge mod_clk or negedge nrst) begin
    if (!nrst) begin
      mod_rst_s1_n_q <= 1'b0;
      mod_nrst_q <= 1'b0;
    end else begin
      mod_rst_s1_n_q <= 1'b1;
      mod_nrst_q <= mod_rst_s1_n_q;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sys_rst_s1_n_q <= 1'b0;
      sys_nrst_q <= 1'b0;
    end else begin
      sys_rst_s1_n_q <= 1'b1;
      sys_nrst_q <= sys_rst_s1_n_q;
    end
  end

  // ---------------- Link domain (modulator clock) ----------------

  // Mode crossing into the link domain
  mode_t mode_s1_q;
  mode_t mode_s2_q;
  mode_t mode_s3_q;
  mode_t mode_q;
  logic restart_q;

  always_ff @(posedge mod_clk or negedge mod_nrst_q) begin
    if (!mod_nrst_q) begin
      mode_s1_q <= MODE_SINC3;
      mode_s2_q <= MODE_SINC3;
      mode_s3_q <= MODE_SINC3;
    end else begin
      mode_s1_q <= mode_sel;
      mode_s2_q <= mode_s1_q;
      mode_s3_q <= mode_s2_q;
    end
  end

  // Adopted once stages 2 and 3 agree; the filter restarts one edge later
  always_ff @(posedge mod_clk or negedge mod_nrst_q) begin
    if (!mod_nrst_q) begin
      mode_q <= MODE_SINC3;
      restart_q <= 1'b0;
    end else begin
      restart_q <= 1'b0;
      if (mode_s2_q == mode_s3_q && mode_s3_q != mode_q) begin
        mode_q <= mode_s3_q;
        restart_q <= 1'b1;
      end
    end
  end

  // Integrators; wrap-around is harmless since the combs undo it
  logic [ACC_W-1:0] integ_in [INT_N];
  logic [ACC_W-1:0] integ_q [INT_N];

  for (genvar g = 0; g < INT_N; g++) begin : g_int
    if (g == 0) begin : g_head
      assign integ_in[g] = ACC_W'(modulator_bitstream_out);
    end else begin : g_chain
      assign integ_in[g] = integ_q[g-1];
    end
    always_ff @(posedge mod_clk or negedge mod_nrst_q) begin
      if (!mod_nrst_q) begin
        integ_q[g] <= '0;
      end else if (restart_q) begin
        integ_q[g] <= '0;
      end else begin
        integ_q[g] <= integ_q[g] + integ_in[g];
      end
    end
  end

  // Decimation counter: one word every 2**OSR_LOG2 bits
  logic [OSR_LOG2-1:0] cnt_q;
  logic tick;

  assign tick = (cnt_q == CNT_LAST);

  always_ff @(posedge mod_clk or negedge mod_nrst_q) begin
    if (!mod_nrst_q) begin
      cnt_q <= '0;
    end else if (restart_q) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // Combs at the decimated rate
  logic [ACC_W-1:0] src;
  logic [ACC_W-1:0] comb_in [COMB_N];
  logic [ACC_W-1:0] comb_out [COMB_N];
  logic [ACC_W-1:0] comb_dly_q [COMB_N];
  logic [ACC_W-1:0] h1_q;
  logic [ACC_W-1:0] h2_q;
  logic [ACC_W-1:0] res;
  logic [ACC_W-1:0] scaled;
  logic [OUT_W-1:0] value;
  logic [2:0] need;

  // Sinc2 taps the middle integrator, sinc3 the last
  assign src = (mode_q == MODE_SINC3) ? integ_q[INT_N-1] : integ_q[INT_N-2];

  for (genvar k = 0; k < COMB_N; k++) begin : g_comb
    if (k == 0) begin : g_head
      assign comb_in[k] = src;
    end else begin : g_chain
      assign comb_in[k] = comb_out[k-1];
    end
    assign comb_out[k] = comb_in[k] - comb_dly_q[k];
    always_ff @(posedge mod_clk or negedge mod_nrst_q) begin
      if (!mod_nrst_q) begin
        comb_dly_q[k] <= '0;
      end else if (restart_q) begin
        comb_dly_q[k] <= '0;
      end else if (tick) begin
        comb_dly_q[k] <= comb_in[k];
      end
    end
  end

  always_comb begin
    case (mode_q)
      MODE_SINC3: begin
        res = comb_out[COMB_N-1];
        scaled = res >> SH3;
        need = SETTLE_SINC3;
      end
      MODE_SINC2: begin
        res = comb_out[COMB_N-2];
        scaled = res >> SH2;
        need = SETTLE_SINC2;
      end
      MODE_FAST: begin
        res = comb_out[COMB_N-2] + h2_q;
        scaled = res >> SHF;
        need = SETTLE_FAST;
      end
      default: begin
        res = comb_out[COMB_N-1];
        scaled = res >> SH3;
        need = SETTLE_SINC3;
      end
    endcase
    // Full-scale all-ones input lands one past the top code
    if (scaled[ACC_W-1:OUT_W] != '0) begin
      value = WORD_MAX;
    end else begin
      value = scaled[OUT_W-1:0];
    end
  end

  // Fast variant adds the sinc2 word from two words back
  always_ff @(posedge mod_clk or negedge mod_nrst_q) begin
    if (!mod_nrst_q) begin
      h1_q <= '0;
      h2_q <= '0;
    end else if (restart_q) begin
      h1_q <= '0;
      h2_q <= '0;
    end else if (tick) begin
      h1_q <= comb_out[COMB_N-2];
      h2_q <= h1_q;
    end
  end

  // Settling: words are withheld until the filter history is full
  logic [2:0] words_q;
  logic settled;

  assign settled = (words_q >= need);

  always_ff @(posedge mod_clk or negedge mod_nrst_q) begin
    if (!mod_nrst_q) begin
      words_q <= '0;
    end else if (restart_q) begin
      words_q <= '0;
    end else if (tick && !settled) begin
      words_q <= words_q + 1'b1;
    end
  end

  // Hand-off register plus toggle; held stable for a full word period
  sample_t hold_q;
  logic tog_q;

  always_ff @(posedge mod_clk or negedge mod_nrst_q) begin
    if (!mod_nrst_q) begin
      hold_q <= SAMPLE_RST;
    end else if (tick && settled && !restart_q) begin
      hold_q <= '{value: value, mode: mode_q};
    end
  end

  always_ff @(posedge mod_clk or negedge mod_nrst_q) begin
    if (!mod_nrst_q) begin
      tog_q <= 1'b0;
    end else if (tick && settled && !restart_q) begin
      tog_q <= ~tog_q;
    end
  end

  // ---------------- System domain (clk) ----------------

  logic tog_s1_q;
  logic tog_s2_q;
  logic tog_s3_q;
  logic seen_q;

  always_ff @(posedge clk or negedge sys_nrst_q) begin
    if (!sys_nrst_q) begin
      tog_s1_q <= 1'b0;
      tog_s2_q <= 1'b0;
      tog_s3_q <= 1'b0;
    end else begin
      tog_s1_q <= tog_q;
      tog_s2_q <= tog_s1_q;
      tog_s3_q <= tog_s2_q;
    end
  end

  // Data is sampled only after the toggle has settled, so hold_q is quiet
  logic take;

  assign take = (tog_s2_q == tog_s3_q) && (tog_s3_q != seen_q);

  always_ff @(posedge clk or negedge sys_nrst_q) begin
    if (!sys_nrst_q) begin
      seen_q <= 1'b0;
      word_valid <= 1'b0;
    end else begin
      word_valid <= take;
      if (take) begin
        seen_q <= tog_s3_q;
      end
    end
  end

  always_ff @(posedge clk or negedge sys_nrst_q) begin
    if (!sys_nrst_q) begin
      word <= SAMPLE_RST;
    end else if (take) begin
      word <= hold_q;
    end
  end

endmodule

`default_nettype wire

/* verif/sinc_rx_asserts.sv */
// Port checks for the decimator
`timescale 1ns/1ps
`default_nettype none
module sinc_rx_asserts
  import sinc_rx_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire mode_t mode_sel,
  input wire sample_t word,
  input wire logic word_valid
);
  logic [9:0] gap_q;
  logic first_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) gap_q <= 10'h000;
    else if (word_valid) gap_q <= 10'h000;
    else if (gap_q != 10'h3FF) gap_q <= gap_q + 10'h001;
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) first_q <= 1'b1;
    else if (word_valid) first_q <= 1'b0;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_quiet; !word_valid [*8]; endsequence
  property p_single; word_valid |=> s_quiet; endproperty
  a_single: assert property (p_single) else $error("pulse");
  // Two clk of crossing jitter allowed
  property p_gap; word_valid && !first_q |-> gap_q >= 10'h0BD; endproperty
  a_gap: assert property (p_gap) else $error("gap");
  property p_first; word_valid && first_q |-> gap_q >= 10'h17C; endproperty
  a_first: assert property (p_first) else $error("settle");
  property p_hold_v; !word_valid |-> $stable(word.value); endproperty
  a_hold_v: assert property (p_hold_v) else $error("value");
  property p_hold_m; !word_valid |-> $stable(word.mode); endproperty
  a_hold_m: assert property (p_hold_m) else $error("mode");
  property p_onehot; word_valid |-> $onehot(word.mode); endproperty
  a_onehot: assert property (p_onehot) else $error("onehot");
  property p_rst_word; $rose(nrst) |-> word == SAMPLE_RST; endproperty
  a_rst_word: assert property (p_rst_word) else $error("rst");
  property p_rst_quiet; $rose(nrst) |-> s_quiet; endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("quiet");
endmodule
bind sinc_rx sinc_rx_asserts chk (.clk(clk), .nrst(nrst), .mode_sel(mode_sel), .word(word),
  .word_valid(word_valid));
`default_nettype wire

/* verif/sinc_dev_model.sv */
// Modulator model: halved clock, fixed ones density
`timescale 1ns/1ps
`default_nettype none
module sinc_dev_model (
  input wire logic [3:0] ones,
  output logic mclk,
  output logic bit_out
);
  logic sys_clk = 1'b0;
  logic [2:0] ph_q = 3'h0;
  initial mclk = 1'b0;
  initial bit_out = 1'b0;
  always #1.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) mclk <= ~mclk;
  // Period of eight keeps every window exact
  always @(negedge mclk) begin
    ph_q <= ph_q + 3'h1;
    bit_out <= {1'b0, ph_q} < ones;
  end
endmodule
`default_nettype wire

/* verif/sinc_rx_tb.sv */
// Bench for the decimator
`timescale 1ns/1ps
`default_nettype none
module sinc_rx_tb;
  import sinc_rx_pkg::*;
  logic clk, nrst, mclk, mbit, word_valid;
  logic [3:0] ones;
  mode_t mode_sel;
  sample_t word;
  int fails, compares;
  sinc_dev_model dev (.ones(ones), .mclk(mclk), .bit_out(mbit));
  sinc_rx #(.OSR_LOG2(8)) dut (.clk(clk), .nrst(nrst), .mod_clk(mclk), .modulator_bitstream_out(mbit),
    .mode_sel(mode_sel), .word(word), .word_valid(word_valid));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic check(input string what, input logic [18:0] seen, input logic [18:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done;
    if (fails == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wait_word(output int n);
    n = 0;
    @(negedge clk);
    while (word_valid !== 1'b1) begin
      n++;
      if (n > 2000) begin
        fails++;
        test_done();
      end
      @(negedge clk);
    end
  endtask
  task automatic reset_run;
    int n;
    @(posedge clk);
    nrst <= 1'b0;
    mode_sel <= MODE_SINC3;
    repeat (8) @(posedge clk);
    check("rst", word, SAMPLE_RST);
    nrst <= 1'b1;
    wait_word(n);
    check("settle", 19'(n > 570), 19'h0_0001);
  endtask
  task automatic run(input mode_t m, input logic [3:0] d);
    int n;
    logic [15:0] exp;
    exp = (d == 4'h8) ? 16'hFFFF : {d[2:0], 13'h0000};
    @(posedge clk);
    mode_sel <= m;
    ones <= d;
    repeat (6) wait_word(n);
    check("word", word, {exp, m});
  endtask
  initial begin
    mode_t modes [3] = '{MODE_SINC3, MODE_SINC2, MODE_FAST};
    logic [3:0] dens [5] = '{4'h0, 4'h1, 4'h4, 4'h7, 4'h8};
    nrst = 1'b0;
    ones = 4'h4;
    mode_sel = MODE_SINC3;
    fails = 0;
    compares = 0;
    reset_run();
    foreach (modes[i]) begin
      foreach (dens[j]) begin
        run(modes[i], dens[j]);
      end
    end
    reset_run();
    run(MODE_FAST, 4'h7);
    test_done();
  end
endmodule
`default_nettype wire
